/* inc/ssrn_map.svh */
// Register offsets, field positions and reset values of the soft request nodes
`ifndef SSRN_MAP_SVH
`define SSRN_MAP_SVH
`define SSRN_OFS_CTRL0 8'h00
`define SSRN_OFS_CTRL1 8'h04
`define SSRN_OFS_CTRL2 8'h08
`define SSRN_OFS_CTRL3 8'h0C
`define SSRN_OFS_CPU 8'h10
`define SSRN_OFS_IRQ_STAT 8'h14
`define SSRN_OFS_IRQ_MASK 8'h18
`define SSRN_OFS_ACK 8'h1C
`define SSRN_PRIO_HI 7
`define SSRN_PRIO_LO 0
`define SSRN_TOS_HI 11
`define SSRN_TOS_LO 10
`define SSRN_ENA_BIT 12
`define SSRN_PEND_BIT 13
`define SSRN_CLR_BIT 14
`define SSRN_SET_BIT 15
`define SSRN_GIE_BIT 8
`define SSRN_IDX_HI 3
`define SSRN_IDX_LO 2
`define SSRN_IRQ_HI 1
`define SSRN_IRQ_LO 0
`define SSRN_ZERO32 32'h0000_0000
`define SSRN_PRIO_MAX 8'hFF
`define SSRN_PRIO_ZERO 8'h00
`define SSRN_RESP_OKAY 2'h0
`define SSRN_RESP_SLVERR 2'h2
`endif

/* inc/ssrn_pkg.sv */
// Types of the soft request node block
package ssrn_pkg;
  typedef logic [7:0] ssrn_prio_t;
  typedef logic [1:0] ssrn_tos_t;
  typedef enum logic [1:0] {
    SSRN_W_IDLE = 2'b00,
    SSRN_W_RESP = 2'b01
  } ssrn_wstate_t;
  typedef enum logic [1:0] {
    SSRN_R_IDLE = 2'b00,
    SSRN_R_RESP = 2'b01
  } ssrn_rstate_t;
endpackage : ssrn_pkg

/* rtl/ssrn_nodes.sv */
// Four software request nodes with priority arbitration and AXI4-Lite slave
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "ssrn_map.svh"

module ssrn_nodes #(
  parameter int NODES = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic take_ack,
  input wire logic rfe_pulse,
  output ssrn_pkg::ssrn_prio_t take_prio,
  output logic take_req,
  output ssrn_pkg::ssrn_tos_t take_tos,
  output logic [1:0] take_node,
  output logic irq
);
  import ssrn_pkg::*;

  // ==========================================================
  // Storage
  ssrn_prio_t prio_reg [NODES];
  ssrn_prio_t prio_next [NODES];
  ssrn_tos_t tos_reg [NODES];
  ssrn_tos_t tos_next [NODES];
  logic [NODES-1:0] ena_reg, ena_next, pend_reg, pend_next;
  ssrn_prio_t cpu_prio_reg, cpu_prio_next, saved_prio_reg, saved_prio_next;
  logic gie_reg, gie_next, saved_gie_reg, saved_gie_next;
  logic [1:0] stat_reg, stat_next, mask_reg, mask_next;
  ssrn_wstate_t wst_reg, wst_next;
  ssrn_rstate_t rst_reg, rst_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic take_req_reg, take_req_next, irq_reg, irq_next;
  ssrn_prio_t take_prio_reg, take_prio_next;
  ssrn_tos_t take_tos_reg, take_tos_next;
  logic [1:0] take_node_reg, take_node_next;

  // ==========================================================
  // Decode helpers
  function automatic logic is_node(input logic [7:0] a);
    is_node = (a == `SSRN_OFS_CTRL0) || (a == `SSRN_OFS_CTRL1) ||
              (a == `SSRN_OFS_CTRL2) || (a == `SSRN_OFS_CTRL3);
  endfunction : is_node

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = is_node(a) || (a == `SSRN_OFS_CPU) || (a == `SSRN_OFS_IRQ_STAT) ||
                (a == `SSRN_OFS_IRQ_MASK) || (a == `SSRN_OFS_ACK);
  endfunction : is_mapped

  // ==========================================================
  // Write channel and register update
  logic do_write;
  logic [1:0] widx;
  logic wfull;
  logic [NODES-1:0] acked;

  always_comb begin
    wst_next = wst_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bresp_next = bresp_reg;
    do_write = 1'b0;
    case (wst_reg)
      SSRN_W_IDLE: begin
        if (s_axi_awvalid && !aw_have_reg) begin
          aw_have_next = 1'b1;
          awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_reg) begin
          w_have_next = 1'b1;
          wdata_next = s_axi_wdata;
          wstrb_next = s_axi_wstrb;
        end
        if (aw_have_reg && w_have_reg) begin
          do_write = 1'b1;
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
          bresp_next = (is_mapped(awaddr_reg) && (&wstrb_reg)) ?
                       `SSRN_RESP_OKAY : `SSRN_RESP_SLVERR;
          wst_next = SSRN_W_RESP;
        end
      end
      SSRN_W_RESP: begin
        if (s_axi_bready) begin
          wst_next = SSRN_W_IDLE;
        end
      end
      default: begin
        wst_next = SSRN_W_IDLE;
      end
    endcase
  end

  assign wfull = do_write && (&wstrb_reg);
  assign widx = awaddr_reg[`SSRN_IDX_HI:`SSRN_IDX_LO];

  always_comb begin
    acked = '0;
    if (take_ack && take_req_reg) begin
      acked[take_node_reg] = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NODES; gi++) begin : g_node
      logic hit;
      assign hit = wfull && is_node(awaddr_reg) && (widx == 2'(gi));
      always_comb begin
        prio_next[gi] = prio_reg[gi];
        tos_next[gi] = tos_reg[gi];
        ena_next[gi] = ena_reg[gi];
        pend_next[gi] = pend_reg[gi];
        if (acked[gi]) begin
          pend_next[gi] = 1'b0;
        end
        if (hit) begin
          prio_next[gi] = wdata_reg[`SSRN_PRIO_HI:`SSRN_PRIO_LO];
          tos_next[gi] = wdata_reg[`SSRN_TOS_HI:`SSRN_TOS_LO];
          ena_next[gi] = wdata_reg[`SSRN_ENA_BIT];
          if (wdata_reg[`SSRN_CLR_BIT] && !wdata_reg[`SSRN_SET_BIT]) begin
            pend_next[gi] = 1'b0;
          end
          // only a write sets, from any master
          if (wdata_reg[`SSRN_SET_BIT]) begin
            pend_next[gi] = 1'b1;
          end
        end
      end
    end
  endgenerate

  // CPU priority state, return restore
  always_comb begin
    cpu_prio_next = cpu_prio_reg;
    gie_next = gie_reg;
    saved_prio_next = saved_prio_reg;
    saved_gie_next = saved_gie_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (take_ack && take_req_reg) begin
      saved_prio_next = cpu_prio_reg;
      saved_gie_next = gie_reg;
      cpu_prio_next = take_prio_reg;
      gie_next = 1'b0;
      stat_next[0] = 1'b1;
    end else if (rfe_pulse) begin
      cpu_prio_next = saved_prio_reg;
      gie_next = saved_gie_reg;
      stat_next[1] = 1'b1;
    end
    if (wfull) begin
      if (awaddr_reg == `SSRN_OFS_CPU) begin
        cpu_prio_next = wdata_reg[`SSRN_PRIO_HI:`SSRN_PRIO_LO];
        gie_next = wdata_reg[`SSRN_GIE_BIT];
      end
      if (awaddr_reg == `SSRN_OFS_IRQ_MASK) begin
        mask_next = wdata_reg[`SSRN_IRQ_HI:`SSRN_IRQ_LO];
      end
      if (awaddr_reg == `SSRN_OFS_IRQ_STAT) begin
        stat_next = stat_reg & ~wdata_reg[`SSRN_IRQ_HI:`SSRN_IRQ_LO];
        if (take_ack && take_req_reg) begin
          stat_next[0] = 1'b1;
        end else if (rfe_pulse) begin
          stat_next[1] = 1'b1;
        end
      end
    end
    irq_next = |(stat_next & mask_next);
  end

  // ==========================================================
  // Arbitration
  // no origin kept, enable and pending
  always_comb begin
    take_prio_next = `SSRN_PRIO_ZERO;
    take_tos_next = '0;
    take_node_next = '0;
    for (int i = 0; i < NODES; i++) begin
      if (ena_next[i] && pend_next[i] && (prio_next[i] > take_prio_next)) begin
        take_prio_next = prio_next[i];
        take_tos_next = tos_next[i];
        take_node_next = i[1:0];
      end
    end
    // strictly greater, 255 blocks, zero idle
    take_req_next = gie_next && (cpu_prio_next != `SSRN_PRIO_MAX) &&
                    (take_prio_next > cpu_prio_next);
  end

  // ==========================================================
  // Read channel
  logic [31:0] rd_word;
  always_comb begin
    rd_word = `SSRN_ZERO32;
    if (is_node(s_axi_araddr)) begin
      rd_word[`SSRN_PRIO_HI:`SSRN_PRIO_LO] = prio_reg[s_axi_araddr[`SSRN_IDX_HI:`SSRN_IDX_LO]];
      rd_word[`SSRN_TOS_HI:`SSRN_TOS_LO] = tos_reg[s_axi_araddr[`SSRN_IDX_HI:`SSRN_IDX_LO]];
      rd_word[`SSRN_ENA_BIT] = ena_reg[s_axi_araddr[`SSRN_IDX_HI:`SSRN_IDX_LO]];
      rd_word[`SSRN_PEND_BIT] = pend_reg[s_axi_araddr[`SSRN_IDX_HI:`SSRN_IDX_LO]];
    end else if (s_axi_araddr == `SSRN_OFS_CPU) begin
      rd_word[`SSRN_PRIO_HI:`SSRN_PRIO_LO] = cpu_prio_reg;
      rd_word[`SSRN_GIE_BIT] = gie_reg;
    end else if (s_axi_araddr == `SSRN_OFS_IRQ_STAT) begin
      rd_word[`SSRN_IRQ_HI:`SSRN_IRQ_LO] = stat_reg;
    end else if (s_axi_araddr == `SSRN_OFS_IRQ_MASK) begin
      rd_word[`SSRN_IRQ_HI:`SSRN_IRQ_LO] = mask_reg;
    end
    rst_next = rst_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    case (rst_reg)
      SSRN_R_IDLE: begin
        if (s_axi_arvalid) begin
          rdata_next = rd_word;
          rresp_next = is_mapped(s_axi_araddr) ? `SSRN_RESP_OKAY : `SSRN_RESP_SLVERR;
          rst_next = SSRN_R_RESP;
        end
      end
      SSRN_R_RESP: begin
        if (s_axi_rready) begin
          rst_next = SSRN_R_IDLE;
        end
      end
      default: begin
        rst_next = SSRN_R_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < NODES; i++) begin
        prio_reg[i] <= `SSRN_PRIO_ZERO;
        tos_reg[i] <= '0;
      end
      ena_reg <= '0;
      pend_reg <= '0;
      cpu_prio_reg <= `SSRN_PRIO_ZERO;
      saved_prio_reg <= `SSRN_PRIO_ZERO;
      gie_reg <= 1'b0;
      saved_gie_reg <= 1'b0;
      stat_reg <= '0;
      mask_reg <= '0;
      wst_reg <= SSRN_W_IDLE;
      rst_reg <= SSRN_R_IDLE;
      awaddr_reg <= '0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      wdata_reg <= `SSRN_ZERO32;
      wstrb_reg <= '0;
      rdata_reg <= `SSRN_ZERO32;
      bresp_reg <= `SSRN_RESP_OKAY;
      rresp_reg <= `SSRN_RESP_OKAY;
      take_req_reg <= 1'b0;
      take_prio_reg <= `SSRN_PRIO_ZERO;
      take_tos_reg <= '0;
      take_node_reg <= '0;
      irq_reg <= 1'b0;
    end else if (ce) begin
      prio_reg <= prio_next;
      tos_reg <= tos_next;
      ena_reg <= ena_next;
      pend_reg <= pend_next;
      cpu_prio_reg <= cpu_prio_next;
      saved_prio_reg <= saved_prio_next;
      gie_reg <= gie_next;
      saved_gie_reg <= saved_gie_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      wst_reg <= wst_next;
      rst_reg <= rst_next;
      awaddr_reg <= awaddr_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      rdata_reg <= rdata_next;
      bresp_reg <= bresp_next;
      rresp_reg <= rresp_next;
      take_req_reg <= take_req_next;
      take_prio_reg <= take_prio_next;
      take_tos_reg <= take_tos_next;
      take_node_reg <= take_node_next;
      irq_reg <= irq_next;
    end
  end

  assign s_axi_awready = !aw_have_reg && (wst_reg == SSRN_W_IDLE);
  assign s_axi_wready = !w_have_reg && (wst_reg == SSRN_W_IDLE);
  assign s_axi_bvalid = (wst_reg == SSRN_W_RESP);
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = (rst_reg == SSRN_R_IDLE);
  assign s_axi_rvalid = (rst_reg == SSRN_R_RESP);
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign take_req = take_req_reg;
  assign take_prio = take_prio_reg;
  assign take_tos = take_tos_reg;
  assign take_node = take_node_reg;
  assign irq = irq_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || !ce);

  sequence s_setwrite;
    wfull && is_node(awaddr_reg) && wdata_reg[`SSRN_SET_BIT];
  endsequence

  AST_SET_PENDS: assert property (s_setwrite |=> pend_reg[$past(widx)])
    else $error("set write did not raise pending");
  AST_CLR_ONLY: assert property (wfull && is_node(awaddr_reg) &&
      wdata_reg[`SSRN_CLR_BIT] && !wdata_reg[`SSRN_SET_BIT] && !take_ack
      |=> !pend_reg[$past(widx)])
    else $error("clear write left pending");
  AST_ONLY_WRITE_SETS: assert property ($rose(pend_reg[0]) |->
      $past(wfull && is_node(awaddr_reg) && widx == 2'h0))
    else $error("pending rose without write");
  AST_STRICT_GT: assert property (take_req |-> take_prio > cpu_prio_reg)
    else $error("request not above cpu priority");
  AST_MAX_BLOCKS: assert property (cpu_prio_reg == `SSRN_PRIO_MAX |-> !take_req)
    else $error("request accepted at 255");
  AST_NEEDS_GIE: assert property (!gie_reg |-> !take_req)
    else $error("request with global enable off");
  AST_ENA_PEND: assert property (take_req |-> ena_reg[take_node] && pend_reg[take_node])
    else $error("request without enable and pending");
  AST_ACK_CLEARS: assert property (take_ack && take_req &&
      !(wfull && is_node(awaddr_reg) && wdata_reg[`SSRN_SET_BIT])
      |=> !pend_reg[$past(take_node)])
    else $error("acknowledge did not clear pending");
  AST_PRIO_WRITE: assert property (wfull && is_node(awaddr_reg) |=>
      prio_reg[$past(widx)] == $past(wdata_reg[`SSRN_PRIO_HI:`SSRN_PRIO_LO]))
    else $error("priority not rewritten");
  AST_PARTIAL_ERR: assert property (do_write && !(&wstrb_reg) |=>
      s_axi_bvalid && s_axi_bresp == `SSRN_RESP_SLVERR)
    else $error("partial write not refused");
endmodule : ssrn_nodes

/* testbench/ssrn_cpu_model.sv */
// Processor side model that takes requests and returns from them
`timescale 1ns/10ps

module ssrn_cpu_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic take_req,
  input wire logic ack_en,
  input wire logic rfe_cmd,
  output logic take_ack,
  output logic rfe_pulse
);
  logic ack_next;
  logic rfe_next;
  // =====================================
  // Acknowledge and return
  always_comb begin
    ack_next = ack_en && take_req && !take_ack;
    rfe_next = rfe_cmd && !rfe_pulse;
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      take_ack <= 1'b0;
      rfe_pulse <= 1'b0;
    end else begin
      take_ack <= ack_next;
      rfe_pulse <= rfe_next;
    end
  end
endmodule : ssrn_cpu_model

/* testbench/ssrn_nodes_tb.sv */
// Self-checking bench of the soft request nodes
`timescale 1ns/10ps
`include "ssrn_map.svh"

module ssrn_nodes_tb;
  import ssrn_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ack_en = 1'b0, rfe_cmd = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, take_node, resp;
  logic [31:0] s_axi_rdata, rd;
  ssrn_prio_t take_prio;
  ssrn_tos_t take_tos;
  logic take_req, take_ack, rfe_pulse, irq;
  int error_cnt = 0;
  int n_compared = 0;
  int k;

  initial begin
    forever #4 clk = ~clk;
  end

  ssrn_nodes ssrn_nodes_i (.clk(clk), .resetn(resetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .take_ack(take_ack), .rfe_pulse(rfe_pulse),
    .take_prio(take_prio), .take_req(take_req), .take_tos(take_tos),
    .take_node(take_node), .irq(irq));

  ssrn_cpu_model ssrn_cpu_model_i (.clk(clk), .resetn(resetn), .take_req(take_req),
    .ack_en(ack_en), .rfe_cmd(rfe_cmd), .take_ack(take_ack), .rfe_pulse(rfe_pulse));

  // =====================================
  // Report and compare
  task test_done;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task chk_resp(input logic [1:0] exp);
    chk({30'h0, resp}, {30'h0, exp});
  endtask : chk_resp

  task hung;
    error_cnt++;
    test_done();
  endtask : hung

  // =====================================
  // Bus cycles
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
    hung();
  endtask : wr

  task rd_reg(input logic [7:0] a);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hung();
  endtask : rd_reg

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    rd_reg(a);
    chk(rd, exp);
  endtask : rchk

  task ack_one;
    int i;
    ack_en <= 1'b1;
    for (i = 0; i < 32; i++) begin
      @(posedge clk);
      if (take_ack) begin
        ack_en <= 1'b0;
        @(posedge clk);
        return;
      end
    end
    hung();
  endtask : ack_one

  task chk_take(input logic r, input logic [7:0] p, input logic [1:0] n);
    chk({31'h0, take_req}, {31'h0, r});
    if (r) chk({22'h0, take_node, take_prio}, {22'h0, n, p});
  endtask : chk_take

  // =====================================
  // Scenarios
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    for (k = 0; k < 4; k++) rchk(8'(k * 4), `SSRN_ZERO32);
    chk_take(1'b0, 8'h00, 2'h0);
    wr(`SSRN_OFS_CTRL1, 32'hFFFF_7FAB, 4'hF);
    rchk(`SSRN_OFS_CTRL1, 32'h0000_1CAB);
    wr(`SSRN_OFS_CTRL1, 32'h0000_00FF, 4'h3);
    chk_resp(`SSRN_RESP_SLVERR);
    rchk(`SSRN_OFS_CTRL1, 32'h0000_1CAB);
    rchk(8'h20, `SSRN_ZERO32);
    chk_resp(`SSRN_RESP_SLVERR);
    // Priorities left free of other sources
    wr(`SSRN_OFS_CPU, 32'h0000_0100, 4'hF);
    wr(`SSRN_OFS_CTRL0, 32'h0000_9001, 4'hF);
    chk_resp(`SSRN_RESP_OKAY);
    chk_take(1'b1, 8'h01, 2'h0);
    ack_one();
    chk_take(1'b0, 8'h00, 2'h0);
    rchk(`SSRN_OFS_CTRL0, 32'h0000_1001);
    rchk(`SSRN_OFS_CPU, 32'h0000_0001);
    wr(`SSRN_OFS_CPU, 32'h0000_0105, 4'hF);
    wr(`SSRN_OFS_CTRL2, 32'h0000_9C05, 4'hF);
    chk_take(1'b0, 8'h00, 2'h0);
    wr(`SSRN_OFS_CTRL2, 32'h0000_1C06, 4'hF);
    chk_take(1'b1, 8'h06, 2'h2);
    chk({30'h0, take_tos}, 32'h0000_0003);
    wr(`SSRN_OFS_CPU, 32'h0000_01FF, 4'hF);
    chk_take(1'b0, 8'h00, 2'h0);
    wr(`SSRN_OFS_CPU, 32'h0000_0100, 4'hF);
    chk_take(1'b1, 8'h06, 2'h2);
    ack_one();
    wr(`SSRN_OFS_CTRL3, 32'h0000_9003, 4'hF);
    chk_take(1'b0, 8'h00, 2'h0);
    rchk(`SSRN_OFS_CPU, 32'h0000_0006);
    rfe_cmd <= 1'b1;
    @(posedge clk);
    rfe_cmd <= 1'b0;
    rchk(`SSRN_OFS_CPU, 32'h0000_0100);
    chk_take(1'b1, 8'h03, 2'h3);
    rchk(`SSRN_OFS_IRQ_STAT, 32'h0000_0003);
    chk({31'h0, irq}, `SSRN_ZERO32);
    wr(`SSRN_OFS_IRQ_MASK, 32'h0000_0001, 4'hF);
    rchk(`SSRN_OFS_IRQ_MASK, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`SSRN_OFS_IRQ_STAT, 32'h0000_0001, 4'hF);
    rchk(`SSRN_OFS_IRQ_STAT, 32'h0000_0002);
    chk({31'h0, irq}, `SSRN_ZERO32);
    // Frozen block ignores an acknowledge
    ce <= 1'b0;
    ack_one();
    ce <= 1'b1;
    chk_take(1'b1, 8'h03, 2'h3);
    wr(`SSRN_OFS_CTRL3, 32'h0000_5003, 4'hF);
    chk_take(1'b0, 8'h00, 2'h0);
    rchk(`SSRN_OFS_CTRL3, 32'h0000_1003);
    test_done();
  end
endmodule : ssrn_nodes_tb
